// [core/hrlp_pkg.sv]
// constants, types and state layout of the hub reset and link power block
// How it works
// - Power-on and the external reset pin each reset the chip; an upstream bus reset clears only upstream-facing state.
// - At power-up an internal timer holds the internal reset for a fixed count.
// - While the external pin is held low the chip sits in standby with clocks stopped.
// - External reset turns the PHY off and releases the differential pairs.
// - External reset aborts every transaction and keeps no earlier state.
// - External reset returns the device address, configuration and link state to their defaults.
// - External reset stops the crystal oscillator and the PLL.
// - An upstream bus reset clears the device address to zero.
// - An upstream bus reset returns the configuration to unconfigured.
// - An upstream bus reset wakes a suspended or sleeping link back to L0.
// - An upstream bus reset is never passed on to any downstream port.
// - The link is in one of L0 on, L1 sleep or L2 suspend.
// - L1 entry completes in under 10 us and L1 exit in under 50 us.
// - L2 entry takes about 3 ms and L2 exit about 2 ms from resume start.
package hrlp_pkg;

  localparam int CLK_PERIOD_NS   = 40;
  localparam int L1_ENTRY_MAX_NS = 10000;
  localparam int L1_EXIT_MAX_NS  = 50000;
  localparam int L2_ENTRY_NS     = 3000000;
  localparam int L2_EXIT_NS      = 2000000;

  // "under" figures: floor, then one cycle less to stay strictly below
  localparam int L1_ENTRY_CYC    = L1_ENTRY_MAX_NS / CLK_PERIOD_NS - 1;
  localparam int L1_EXIT_CYC     = L1_EXIT_MAX_NS / CLK_PERIOD_NS - 1;
  localparam int L2_ENTRY_CYC    = L2_ENTRY_NS / CLK_PERIOD_NS;
  localparam int L2_EXIT_CYC     = L2_EXIT_NS / CLK_PERIOD_NS;
  localparam int POR_HOLD_CYC    = 1024;

  localparam int CNT_W           = 17;
  localparam int ADDR_W          = 7;

  localparam logic [1:0] LS_L0   = 2'h0;
  localparam logic [1:0] LS_L1   = 2'h1;
  localparam logic [1:0] LS_L2   = 2'h2;

  typedef enum logic [2:0] {R_POR, R_STANDBY, R_OSC, R_PLL, R_RUN} hrlp_rst_t;
  typedef enum logic [2:0] {
    LK_L0, LK_L1_ENT, LK_L1, LK_L1_EXIT, LK_L2_ENT, LK_L2, LK_L2_EXIT
  } hrlp_link_t;

  typedef struct packed {
    logic [2:0]        pin_sync;
    logic [2:0]        osc_sync;
    logic [2:0]        pll_sync;
    logic              pin_low;
    logic              osc_ok;
    logic              pll_ok;
    hrlp_rst_t         rst;
    logic [CNT_W-1:0]  rcnt;
    hrlp_link_t        link;
    logic [CNT_W-1:0]  lcnt;
    logic [ADDR_W-1:0] addr;
    logic              configured;
  } hrlp_state_t;

  localparam hrlp_state_t ST_RESET = '{
    pin_sync:   3'h7,
    osc_sync:   3'h0,
    pll_sync:   3'h0,
    pin_low:    1'b0,
    osc_ok:     1'b0,
    pll_ok:     1'b0,
    rst:        R_POR,
    rcnt:       '0,
    link:       LK_L0,
    lcnt:       '0,
    addr:       '0,
    configured: 1'b0
  };

endpackage : hrlp_pkg

// [core/hrlp_top.sv]
// reset sequencing, bus reset handling and link power states of the hub
module hrlp_top
  import hrlp_pkg::*;
#(
  parameter int POR_CYC    = POR_HOLD_CYC,
  parameter int L1_ENT_CYC = L1_ENTRY_CYC,
  parameter int L1_EXI_CYC = L1_EXIT_CYC,
  parameter int L2_ENT_CYC = L2_ENTRY_CYC,
  parameter int L2_EXI_CYC = L2_EXIT_CYC
) (
  input  wire logic              CLK_SYS,
  input  wire logic              RESET_N,
  input  wire logic              EXT_RESET_PIN_N,
  input  wire logic              OSC_READY,
  input  wire logic              PLL_LOCK,
  input  wire logic              BUS_RESET,
  input  wire logic              SET_ADDR,
  input  wire logic [ADDR_W-1:0] ADDR_IN,
  input  wire logic              SET_CONFIG,
  input  wire logic              CONFIG_IN,
  input  wire logic              L1_REQ,
  input  wire logic              L2_REQ,
  input  wire logic              RESUME,
  output logic                   INT_RESET_N,
  output logic                   STANDBY,
  output logic                   OSC_EN,
  output logic                   PLL_EN,
  output logic                   PHY_EN,
  output logic                   PAIR_OE,
  output logic                   XFER_ABORT,
  output logic [ADDR_W-1:0]      DEV_ADDR,
  output logic                   CONFIGURED,
  output logic [1:0]             LINK_STATE,
  output logic                   LINK_BUSY
);

  localparam int CNT_MAX = (1 << CNT_W) - 1;

  if (POR_CYC < 1 || POR_CYC > CNT_MAX || L1_ENT_CYC < 1 || L1_ENT_CYC > CNT_MAX ||
      L1_EXI_CYC < 1 || L1_EXI_CYC > CNT_MAX || L2_ENT_CYC < 1 || L2_ENT_CYC > CNT_MAX ||
      L2_EXI_CYC < 1 || L2_EXI_CYC > CNT_MAX) begin : g_bad_count
    $error("hrlp_top: a cycle count is outside 1 .. counter range");
  end

  localparam logic [CNT_W-1:0] POR_LAST = CNT_W'(POR_CYC - 1);
  localparam logic [CNT_W-1:0] L1E_LAST = CNT_W'(L1_ENT_CYC - 1);
  localparam logic [CNT_W-1:0] L1X_LAST = CNT_W'(L1_EXI_CYC - 1);
  localparam logic [CNT_W-1:0] L2E_LAST = CNT_W'(L2_ENT_CYC - 1);
  localparam logic [CNT_W-1:0] L2X_LAST = CNT_W'(L2_EXI_CYC - 1);

  hrlp_state_t st_r;
  hrlp_state_t st_nxt;

  ////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    st_nxt = st_r;

    // three-stage synchronisers; a change counts once stages two and three agree
    st_nxt.pin_sync = {st_r.pin_sync[1:0], EXT_RESET_PIN_N};
    st_nxt.osc_sync = {st_r.osc_sync[1:0], OSC_READY};
    st_nxt.pll_sync = {st_r.pll_sync[1:0], PLL_LOCK};
    if (st_r.pin_sync[1] == st_r.pin_sync[2]) begin
      st_nxt.pin_low = ~st_r.pin_sync[2];
    end
    if (st_r.osc_sync[1] == st_r.osc_sync[2]) begin
      st_nxt.osc_ok = st_r.osc_sync[2];
    end
    if (st_r.pll_sync[1] == st_r.pll_sync[2]) begin
      st_nxt.pll_ok = st_r.pll_sync[2];
    end

    // chip reset sequence
    if (st_r.pin_low) begin
      st_nxt.rst = R_STANDBY;
      st_nxt.rcnt = '0;
    end else begin
      unique case (st_r.rst)
        R_POR: begin
          if (st_r.rcnt == POR_LAST) begin
            st_nxt.rst = R_OSC;
            st_nxt.rcnt = '0;
          end else begin
            st_nxt.rcnt = st_r.rcnt + CNT_W'(1);
          end
        end
        R_STANDBY: begin
          st_nxt.rst = R_OSC;
        end
        R_OSC: begin
          if (st_r.osc_ok) begin
            st_nxt.rst = R_PLL;
          end
        end
        R_PLL: begin
          if (st_r.pll_ok) begin
            st_nxt.rst = R_RUN;
          end
        end
        R_RUN: begin
          if (!st_r.osc_ok || !st_r.pll_ok) begin
            st_nxt.rst = R_OSC;
          end
        end
        // unused codes restart the whole sequence
        default: begin
          st_nxt.rst = R_POR;
        end
      endcase
    end

    if (st_nxt.rst != R_RUN) begin
      // nothing survives a chip reset: address, configuration, link
      st_nxt.link = LK_L0;
      st_nxt.lcnt = '0;
      st_nxt.addr = '0;
      st_nxt.configured = 1'b0;
    end else if (BUS_RESET) begin
      // only upstream-facing state is touched; no downstream reset exists here
      st_nxt.addr = '0;
      st_nxt.configured = 1'b0;
      st_nxt.link = LK_L0;
      st_nxt.lcnt = '0;
    end else begin
      if (SET_ADDR) begin
        st_nxt.addr = ADDR_IN;
      end
      if (SET_CONFIG) begin
        st_nxt.configured = CONFIG_IN;
      end
      unique case (st_r.link)
        LK_L0: begin
          if (L1_REQ) begin
            st_nxt.link = LK_L1_ENT;
            st_nxt.lcnt = L1E_LAST;
          end else if (L2_REQ) begin
            st_nxt.link = LK_L2_ENT;
            st_nxt.lcnt = L2E_LAST;
          end
        end
        LK_L1: begin
          if (RESUME) begin
            st_nxt.link = LK_L1_EXIT;
            st_nxt.lcnt = L1X_LAST;
          end
        end
        LK_L2: begin
          if (RESUME) begin
            st_nxt.link = LK_L2_EXIT;
            st_nxt.lcnt = L2X_LAST;
          end
        end
        LK_L1_ENT, LK_L1_EXIT, LK_L2_ENT, LK_L2_EXIT: begin
          if (st_r.lcnt == '0) begin
            unique case (st_r.link)
              LK_L1_ENT: st_nxt.link = LK_L1;
              LK_L2_ENT: st_nxt.link = LK_L2;
              default:   st_nxt.link = LK_L0;
            endcase
          end else begin
            st_nxt.lcnt = st_r.lcnt - CNT_W'(1);
          end
        end
        default: begin
          st_nxt.link = LK_L0;
        end
      endcase
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (!RESET_N) begin
      st_r <= ST_RESET;
    end else begin
      st_r <= st_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  // raw pin drops internal reset at once; release waits for the clocked sequence
  assign INT_RESET_N = EXT_RESET_PIN_N & RESET_N & (st_r.rst == R_RUN);
  assign STANDBY     = (st_r.rst == R_STANDBY);
  // clocks stay stopped in standby and during the POR count; the oscillator starts in R_OSC
  assign OSC_EN      = (st_r.rst == R_OSC) || (st_r.rst == R_PLL) ||
                       (st_r.rst == R_RUN);
  assign PLL_EN      = (st_r.rst == R_PLL) || (st_r.rst == R_RUN);
  assign PHY_EN      = (st_r.rst == R_RUN);
  assign PAIR_OE     = (st_r.rst == R_RUN);
  assign XFER_ABORT  = (st_r.rst != R_RUN);
  assign DEV_ADDR    = st_r.addr;
  assign CONFIGURED  = st_r.configured;
  assign LINK_BUSY   = (st_r.link == LK_L1_ENT) || (st_r.link == LK_L1_EXIT) ||
                       (st_r.link == LK_L2_ENT) || (st_r.link == LK_L2_EXIT);
  always_comb begin
    unique case (st_r.link)
      LK_L1:   LINK_STATE = LS_L1;
      LK_L2:   LINK_STATE = LS_L2;
      default: LINK_STATE = LS_L0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks

  wire run_now = (st_r.rst == R_RUN);

  property p_standby_clocks;
    @(posedge CLK_SYS) disable iff (!RESET_N)
    st_r.pin_low |=> STANDBY && !OSC_EN && !PLL_EN;
  endproperty
  a_standby_clocks: assert property (p_standby_clocks)
    else $error("standby without clocks stopped");

  property p_phy_off;
    @(posedge CLK_SYS) disable iff (!RESET_N)
    !run_now |-> !PHY_EN && !PAIR_OE && XFER_ABORT && !INT_RESET_N;
  endproperty
  a_phy_off: assert property (p_phy_off)
    else $error("phy active outside run");

  property p_regs_default;
    @(posedge CLK_SYS) disable iff (!RESET_N)
    st_r.pin_low |=> DEV_ADDR == '0 && !CONFIGURED && LINK_STATE == LS_L0;
  endproperty
  a_regs_default: assert property (p_regs_default)
    else $error("state kept across external reset");

  property p_bus_addr;
    @(posedge CLK_SYS) disable iff (!RESET_N)
    BUS_RESET |=> DEV_ADDR == '0;
  endproperty
  a_bus_addr: assert property (p_bus_addr)
    else $error("address not cleared by bus reset");

  property p_bus_cfg;
    @(posedge CLK_SYS) disable iff (!RESET_N)
    BUS_RESET && SET_CONFIG && CONFIG_IN |=> !CONFIGURED;
  endproperty
  a_bus_cfg: assert property (p_bus_cfg)
    else $error("configured after bus reset");

  property p_bus_wake;
    @(posedge CLK_SYS) disable iff (!RESET_N)
    BUS_RESET && LINK_STATE != LS_L0 |=> LINK_STATE == LS_L0 && !LINK_BUSY;
  endproperty
  a_bus_wake: assert property (p_bus_wake)
    else $error("bus reset did not wake link");

  property p_link_legal;
    @(posedge CLK_SYS) disable iff (!RESET_N)
    LINK_STATE != 2'h3 && !(LINK_BUSY && LINK_STATE != LS_L0);
  endproperty
  a_link_legal: assert property (p_link_legal)
    else $error("illegal link state");

  property p_l1_entry;
    @(posedge CLK_SYS) disable iff (!RESET_N)
    run_now && st_r.link == LK_L0 && L1_REQ && !BUS_RESET && st_nxt.rst == R_RUN
      |=> LINK_BUSY [*1] ##[0:249] (LINK_STATE == LS_L1 || BUS_RESET || st_nxt.rst != R_RUN);
  endproperty
  a_l1_entry: assert property (p_l1_entry)
    else $error("l1 entry too slow");

  property p_int_reset;
    @(posedge CLK_SYS) disable iff (!RESET_N)
    !EXT_RESET_PIN_N |-> !INT_RESET_N;
  endproperty
  a_int_reset: assert property (p_int_reset)
    else $error("internal reset not asserted with pin");

  property p_por_hold;
    @(posedge CLK_SYS)
    $rose(RESET_N) |-> !INT_RESET_N [*4];
  endproperty
  a_por_hold: assert property (p_por_hold)
    else $error("internal reset released too early after power-on");

endmodule : hrlp_top

// [tb/hrlp_clk_src.sv]
// crystal oscillator and pll model answering the block's enables
module hrlp_clk_src (
  input  wire logic clk_sys,
  input  wire logic osc_en,
  input  wire logic pll_en,
  output logic      osc_ready,
  output logic      pll_lock
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] osc_sh_r;
  logic [1:0] pll_sh_r;
  // startup takes two cycles; a halted source drops its flag at once
  always @(posedge clk_sys) begin
    osc_sh_r <= osc_en ? {osc_sh_r[0], 1'b1} : 2'h0;
    pll_sh_r <= (pll_en && osc_sh_r[1]) ? {pll_sh_r[0], 1'b1} : 2'h0;
  end
  initial begin
    osc_sh_r = 2'h0;
    pll_sh_r = 2'h0;
  end
  assign osc_ready = osc_en & osc_sh_r[1];
  assign pll_lock  = pll_en & pll_sh_r[1];
endmodule : hrlp_clk_src

// [tb/hub_reset_and_link_power_tb_top.sv]
// self-checking bench for the reset and link power block
module hub_reset_and_link_power_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import hrlp_pkg::*;
  localparam int L1E = 5;
  localparam int L1X = 5;
  localparam int L2E = 20;
  localparam int L2X = 10;
  logic clk_sys, reset_n, pin_n, osc_ready, pll_lock, bus_reset, set_addr, set_config;
  logic config_in, l1_req, l2_req, resume, int_reset_n, standby, osc_en, pll_en;
  logic phy_en, pair_oe, xfer_abort, configured, link_busy;
  logic [ADDR_W-1:0] addr_in, dev_addr;
  logic [1:0]        link_state;
  int                mismatches, checks, cycles;

  hrlp_top #(.POR_CYC(4), .L1_ENT_CYC(L1E), .L1_EXI_CYC(L1X), .L2_ENT_CYC(L2E),
    .L2_EXI_CYC(L2X)) hrlp_top_inst (
    .CLK_SYS(clk_sys), .RESET_N(reset_n), .EXT_RESET_PIN_N(pin_n),
    .OSC_READY(osc_ready), .PLL_LOCK(pll_lock), .BUS_RESET(bus_reset),
    .SET_ADDR(set_addr), .ADDR_IN(addr_in), .SET_CONFIG(set_config),
    .CONFIG_IN(config_in), .L1_REQ(l1_req), .L2_REQ(l2_req), .RESUME(resume),
    .INT_RESET_N(int_reset_n), .STANDBY(standby), .OSC_EN(osc_en), .PLL_EN(pll_en),
    .PHY_EN(phy_en), .PAIR_OE(pair_oe), .XFER_ABORT(xfer_abort), .DEV_ADDR(dev_addr),
    .CONFIGURED(configured), .LINK_STATE(link_state), .LINK_BUSY(link_busy));
  hrlp_clk_src hrlp_clk_src_inst (.clk_sys(clk_sys), .osc_en(osc_en), .pll_en(pll_en),
    .osc_ready(osc_ready), .pll_lock(pll_lock));

  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
    #2;
  endtask : cyc

  task automatic wait_run();
    int i;
    for (i = 0; i < 40 && int_reset_n !== 1'b1; i++) cyc(1);
    chk(int_reset_n, 8'h01);
    chk({phy_en, pair_oe, xfer_abort, osc_en, pll_en}, 8'h1B);
  endtask : wait_run

  // waits out a link transition and bounds its length
  task automatic wait_link(input int n, input logic [1:0] st);
    int i;
    for (i = 0; i < n + 4 && link_busy !== 1'b0; i++) cyc(1);
    chk({7'h00, i + 1 >= n && i <= n + 1}, 8'h01);
    chk(link_state, st);
  endtask : wait_link

  task automatic t_regs();
    set_addr = 1'b1; addr_in = 7'h05; set_config = 1'b1; config_in = 1'b1;
    cyc(1);
    set_addr = 1'b0;
    config_in = 1'b0;
    chk(dev_addr, 8'h05);
    chk(configured, 8'h01);
    // config strobe held one more cycle with the value low: unconfigure
    cyc(1);
    chk(configured, 8'h00);
    chk(dev_addr, 8'h05);
    // strobes alongside a bus reset must lose
    bus_reset = 1'b1;
    set_addr = 1'b1;
    addr_in = 7'h7F;
    config_in = 1'b1;
    cyc(1);
    bus_reset = 1'b0; set_addr = 1'b0; set_config = 1'b0;
    chk(dev_addr, 8'h00);
    chk(configured, 8'h00);
    chk({phy_en, int_reset_n}, 8'h03);
    $display("test regs done");
  endtask : t_regs

  task automatic t_link();
    l1_req = 1'b1;
    cyc(1);
    l1_req = 1'b0;
    chk(link_busy, 8'h01);
    wait_link(L1E, LS_L1);
    resume = 1'b1;
    cyc(1);
    resume = 1'b0;
    wait_link(L1X, LS_L0);
    l2_req = 1'b1;
    cyc(1);
    l2_req = 1'b0;
    l1_req = 1'b1;
    cyc(1);
    l1_req = 1'b0;
    wait_link(L2E, LS_L2);
    resume = 1'b1;
    cyc(1);
    resume = 1'b0;
    wait_link(L2X, LS_L0);
    l2_req = 1'b1;
    cyc(1);
    l2_req = 1'b0;
    wait_link(L2E, LS_L2);
    bus_reset = 1'b1;
    cyc(1);
    bus_reset = 1'b0;
    cyc(1);
    chk({link_state, link_busy}, 8'h00);
    $display("test link done");
  endtask : t_link

  task automatic t_ext();
    set_addr = 1'b1; addr_in = 7'h2A; set_config = 1'b1; config_in = 1'b1;
    cyc(1);
    set_addr = 1'b0; set_config = 1'b0;
    l1_req = 1'b1;
    cyc(1);
    l1_req = 1'b0;
    pin_n = 1'b0;
    #1;
    chk(int_reset_n, 8'h00);
    cyc(6);
    chk(standby, 8'h01);
    chk({phy_en, pair_oe}, 8'h00);
    chk(xfer_abort, 8'h01);
    chk({dev_addr, configured}, 8'h00);
    chk({link_state, link_busy}, 8'h00);
    chk({osc_en, pll_en}, 8'h00);
    pin_n = 1'b1;
    wait_run();
    chk({standby, dev_addr}, 8'h00);
    $display("test ext reset done");
  endtask : t_ext

  task automatic final_report();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : final_report

  // runaway guard, far above the roughly 120 cycles the tests need
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 5000) begin
      mismatches++;
      $display("MISMATCH t=%0t run timed out", $time);
      final_report();
    end
  end

  initial begin
    {bus_reset, set_addr, set_config, config_in, l1_req, l2_req, resume} = 7'h00;
    addr_in = 7'h00; pin_n = 1'b1; reset_n = 1'b0;
    mismatches = 0; checks = 0; cycles = 0;
    cyc(5);
    chk({int_reset_n, phy_en, pair_oe, osc_en, xfer_abort}, 8'h01);
    chk({dev_addr, configured}, 8'h00);
    reset_n = 1'b1;
    wait_run();
    $display("test boot done");
    t_regs();
    t_link();
    t_ext();
    final_report();
  end
endmodule : hub_reset_and_link_power_tb_top
